// file: ioe_pkg.sv
// constants and types shared by the i/o element block
package ioe_pkg;
   localparam int NUM_LINES    = 12;
   localparam int NUM_DED      = 6;
   localparam int NUM_IOE      = 4;
   localparam int NUM_GLOBAL   = 4;
   localparam int SRC_W        = 3;
   // peripheral control line slots
   localparam int SLOT_OE0     = 0;
   localparam int SLOT_CE0     = 6;
   localparam int SLOT_PERIPH_CLOCK    = 6;
   localparam int SLOT_OE6     = 7;
   localparam int SLOT_PERIPH_CLEAR    = 8;
   localparam int SLOT_OE7     = 9;
   localparam int SLOT_CLR1    = 10;
   localparam int SLOT_CLK1    = 11;
   localparam int SLOT_GLB0    = 6;
   localparam int SLOT_GLB1    = 7;
   localparam int SLOT_GLB2    = 9;
   localparam int SLOT_GLB3    = 11;
   // line source encodings
   localparam logic [2:0] SRC_ROW_CELL = 3'h6;
   localparam logic [2:0] SRC_COL_ROUTE = 3'h7;
   // io element clock select
   localparam logic [1:0] CLK_SEL_BUS0 = 2'h0;
   localparam logic [1:0] CLK_SEL_BUS1 = 2'h1;
   localparam logic [1:0] CLK_SEL_PIN0 = 2'h2;
   localparam logic [1:0] CLK_SEL_PIN1 = 2'h3;
   // io element clear select
   localparam logic [1:0] CLR_SEL_NONE = 2'h0;
   localparam logic [1:0] CLR_SEL_PERIPH_CLEAR = 2'h1;
   localparam logic [1:0] CLR_SEL_CLR1 = 2'h2;
   // clock enable select: 0..5 bus slots
   localparam logic [2:0] CE_SEL_CELL  = 3'h6;
   localparam logic [2:0] CE_SEL_ON    = 3'h7;
   // output enable select: 0..7 bus slots
   localparam logic [3:0] OE_SEL_CELL  = 4'h8;
   localparam logic [3:0] OE_SEL_ON    = 4'h9;
   // inversion mask bit positions
   localparam int INV_DATA     = 0;
   localparam int INV_CE       = 1;
   localparam int INV_OE       = 2;
   // reset values
   localparam logic IOE_REG_RST  = 1'b0;
   localparam logic CELL_REG_RST = 1'b0;

   typedef enum logic [1:0] {
      IOE_DIR_INPUT  = 2'h0,
      IOE_DIR_OUTPUT = 2'h1,
      IOE_DIR_BIDIR  = 2'h3
   } ioe_dir_type;

   typedef enum logic [2:0] {
      CELL_ASYNC_CLEAR     = 3'h0,
      CELL_ASYNC_PRESET    = 3'h1,
      CELL_CLEAR_PRESET    = 3'h2,
      CELL_LOAD_CLEAR      = 3'h3,
      CELL_LOAD_PRESET     = 3'h4,
      CELL_LOAD_ONLY       = 3'h5
   } ioe_cell_mode_type;
endpackage

// file: ioe_pcb_if.sv
// peripheral control bus carried between the block's modules
interface ioe_pcb_if;
   import ioe_pkg::*;
   logic [NUM_LINES-1:0]  line;
   logic [NUM_GLOBAL-1:0] global_line;
   modport src  (output line, output global_line);
   modport sink (input line, input global_line);
endinterface

// file: ioe_ctrl_bus.sv
// builds the twelve peripheral control lines from their sources
module ioe_ctrl_bus
   import ioe_pkg::*;
(
   input  wire logic [NUM_DED-1:0]         ded_in,
   input  wire logic [NUM_LINES-1:0]       row_cell_in,
   input  wire logic [NUM_LINES-1:0]       col_route_in,
   input  wire logic [NUM_LINES*SRC_W-1:0] line_src_sel,
   input  wire logic [NUM_LINES-1:0]       line_invert,
   ioe_pcb_if.src                          pcb
);
   genvar g;
   generate
      for (g = 0; g < NUM_LINES; g++) begin : g_line
         logic [SRC_W-1:0] sel;
         logic             raw;
         assign sel = line_src_sel[g*SRC_W +: SRC_W];
         always_comb begin
            // any dedicated input, a row's first logic cell or a column route
            if (sel == SRC_ROW_CELL)
               raw = row_cell_in[g];
            else if (sel == SRC_COL_ROUTE)
               raw = col_route_in[g];
            else
               raw = ded_in[sel];
         end
         // each polarity of one input costs its own line
         assign pcb.line[g] = raw ^ line_invert[g];
      end
   endgenerate

   assign pcb.global_line = {pcb.line[SLOT_GLB3], pcb.line[SLOT_GLB2],
                             pcb.line[SLOT_GLB1], pcb.line[SLOT_GLB0]};
endmodule

// file: ioe_cell_reg.sv
// logic cell register with its clear, preset and load modes
module ioe_cell_reg
   import ioe_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire logic              chip_rst,
   input  wire ioe_cell_mode_type mode,
   input  wire logic              ce,
   input  wire logic              d,
   input  wire logic              cell_data_input_three,
   input  wire logic              async_load_ctrl,
   input  wire logic              preset_ctrl_line,
   output logic                   q
);
   logic q_reg;
   logic store_reg;
   logic hold;
   logic force_val;
   logic force_en;

   // preset built from clear plus inversion: store holds the complement
   assign hold = (mode == CELL_LOAD_PRESET) ? ~q_reg : q_reg;

   always_comb begin
      force_en  = 1'b0;
      force_val = 1'b0;
      case (mode)
         CELL_ASYNC_CLEAR: begin
            force_en  = async_load_ctrl | preset_ctrl_line;
            force_val = 1'b0;
         end
         CELL_ASYNC_PRESET: begin
            force_en  = async_load_ctrl;
            force_val = 1'b1;
         end
         CELL_CLEAR_PRESET: begin
            force_en  = async_load_ctrl | preset_ctrl_line;
            force_val = ~preset_ctrl_line;
         end
         CELL_LOAD_CLEAR: begin
            force_en  = async_load_ctrl | preset_ctrl_line;
            force_val = ~preset_ctrl_line & cell_data_input_three;
         end
         CELL_LOAD_PRESET: begin
            // preset line wins, load line writes data
            force_en  = async_load_ctrl | preset_ctrl_line;
            force_val = preset_ctrl_line | cell_data_input_three;
         end
         CELL_LOAD_ONLY: begin
            // load drives preset and clear together
            force_en  = async_load_ctrl;
            force_val = cell_data_input_three;
         end
         default: begin
            force_en  = 1'b0;
            force_val = 1'b0;
         end
      endcase
   end

   // stored value kept inverted in load-with-preset mode
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         store_reg <= CELL_REG_RST;
      else if (chip_rst)
         store_reg <= CELL_REG_RST;
      else if (force_en)
         store_reg <= (mode == CELL_LOAD_PRESET) ? ~force_val : force_val;
      else if (ce)
         store_reg <= (mode == CELL_LOAD_PRESET) ? ~d : d;
   end

   // both stages cleared so no stale value follows a short chip reset
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst)
         q_reg <= CELL_REG_RST;
      else if (chip_rst)
         q_reg <= CELL_REG_RST;
      else
         q_reg <= store_reg;
   end

   // output inversion undoes the stored complement; async path bypasses
   always_comb begin
      if (chip_rst)
         q = CELL_REG_RST;
      else if (force_en)
         q = force_val;
      else
         q = hold;
   end
endmodule

// file: ioe_top.sv
// i/o elements with pin buffer, register and peripheral control bus
// What this block does
// - load-with-preset: preset line presets, load line loads, data inverted
// - load-only mode: load line forces third data input via preset and clear
// - each element: two-way pin buffer, one register, in/out/bidir
// - routed signals into an element may be inverted per signal
// - clock, clear, enable and output enable picked from twelve lines
// - lines give up to eight enables, six clock enables, two clocks, two clears
// - six lines are output enables; clock-enable lines double as others
// - logic cells can drive clock enable and output enable directly
// - element clock may also come from either dedicated clock pin
// - each line driven by dedicated input, row cell or column route
// - chip-wide reset clears every element register above all else
// - dedicated clock pin inversion is one setting for all elements
// - true and inverted use of one input takes two lines
// - six dedicated inputs feed global controls and data
// - chip-wide output enable low-active; inactive floats every pin
module ioe_top
   import ioe_pkg::*;
(
   input  wire logic                         clk,
   input  wire logic                         sys_rst,
   input  wire logic                         chip_rst,
   input  wire logic                         chip_oe_n,
   input  wire logic [NUM_DED-1:0]           ded_in,
   input  wire logic [1:0]                   ded_clk_pin,
   input  wire logic                         ded_clk_invert,
   input  wire logic [NUM_LINES-1:0]         row_cell_in,
   input  wire logic [NUM_LINES-1:0]         col_route_in,
   input  wire logic [NUM_LINES*SRC_W-1:0]   line_src_sel,
   input  wire logic [NUM_LINES-1:0]         line_invert,
   input  wire logic [NUM_IOE*2-1:0]         ioe_dir,
   input  wire logic [NUM_IOE-1:0]           ioe_reg_is_input,
   input  wire logic [NUM_IOE-1:0]           ioe_reg_used,
   input  wire logic [NUM_IOE*2-1:0]         ioe_clk_sel,
   input  wire logic [NUM_IOE*2-1:0]         ioe_clr_sel,
   input  wire logic [NUM_IOE*3-1:0]         ioe_ce_sel,
   input  wire logic [NUM_IOE*4-1:0]         ioe_oe_sel,
   input  wire logic [NUM_IOE*3-1:0]         ioe_invert,
   input  wire logic [NUM_IOE-1:0]           ioe_row_data,
   input  wire logic [NUM_IOE-1:0]           ioe_cell_ce,
   input  wire logic [NUM_IOE-1:0]           ioe_cell_oe,
   input  wire logic [NUM_IOE-1:0]           pin_in,
   output logic [NUM_IOE-1:0]                pin_out,
   output logic [NUM_IOE-1:0]                pin_oe,
   output logic [NUM_IOE-1:0]                ioe_to_row,
   output logic [NUM_GLOBAL-1:0]             global_distribution_line,
   input  wire ioe_cell_mode_type            cell_mode,
   input  wire logic                         cell_ce,
   input  wire logic                         cell_d,
   input  wire logic                         cell_data_input_three,
   input  wire logic                         async_load_ctrl,
   input  wire logic                         preset_ctrl_line,
   output logic                              cell_q
);
   ioe_pcb_if pcb ();

   ioe_ctrl_bus u_bus (
      .ded_in       (ded_in),
      .row_cell_in  (row_cell_in),
      .col_route_in (col_route_in),
      .line_src_sel (line_src_sel),
      .line_invert  (line_invert),
      .pcb          (pcb)
   );

   ioe_cell_reg u_cell (
      .clk                   (clk),
      .sys_rst               (sys_rst),
      .chip_rst              (chip_rst),
      .mode                  (cell_mode),
      .ce                    (cell_ce),
      .d                     (cell_d),
      .cell_data_input_three (cell_data_input_three),
      .async_load_ctrl       (async_load_ctrl),
      .preset_ctrl_line      (preset_ctrl_line),
      .q                     (cell_q)
   );

   assign global_distribution_line = pcb.global_line;

   // shared slot views of the bus: six pure enables, six dual-use
   logic [7:0] output_enable_slot;
   logic [5:0] clock_enable_slot;
   logic [1:0] periph_clock;
   logic [1:0] periph_clear;
   logic [1:0] ded_clk_eff;

   always_comb begin
      output_enable_slot = {pcb.line[SLOT_OE7], pcb.line[SLOT_OE6],
                            pcb.line[SLOT_OE0 +: 6]};
      clock_enable_slot  = pcb.line[SLOT_CE0 +: 6];
      periph_clock       = {pcb.line[SLOT_CLK1], pcb.line[SLOT_PERIPH_CLOCK]};
      periph_clear       = {pcb.line[SLOT_CLR1], pcb.line[SLOT_PERIPH_CLEAR]};
   end

   // one polarity setting serves every element
   assign ded_clk_eff = ded_clk_pin ^ {2{ded_clk_invert}};

   genvar g;
   generate
      for (g = 0; g < NUM_IOE; g++) begin : g_ioe
         logic [1:0]  clk_sel;
         logic [1:0]  clr_sel;
         logic [2:0]  ce_sel;
         logic [3:0]  oe_sel;
         logic [2:0]  inv;
         ioe_dir_type dir;
         logic        sel_clk;
         logic        sel_clr;
         logic        sel_ce;
         logic        sel_oe;
         logic        row_d;
         logic        clk_prev_reg;
         logic        clk_rise;
         logic        q_reg;
         logic        to_row_reg;
         logic        drive;

         assign clk_sel = ioe_clk_sel[g*2 +: 2];
         assign clr_sel = ioe_clr_sel[g*2 +: 2];
         assign ce_sel  = ioe_ce_sel[g*3 +: 3];
         assign oe_sel  = ioe_oe_sel[g*4 +: 4];
         assign inv     = ioe_invert[g*3 +: 3];
         assign dir     = ioe_dir_type'(ioe_dir[g*2 +: 2]);

         // per-signal inversion of routed inputs
         assign row_d = ioe_row_data[g] ^ inv[INV_DATA];

         // controls chosen from the shared bus
         always_comb begin
            case (clk_sel)
               CLK_SEL_BUS0: sel_clk = periph_clock[0];
               CLK_SEL_BUS1: sel_clk = periph_clock[1];
               CLK_SEL_PIN0: sel_clk = ded_clk_eff[0];
               CLK_SEL_PIN1: sel_clk = ded_clk_eff[1];
               default:      sel_clk = periph_clock[0];
            endcase
         end

         always_comb begin
            case (clr_sel)
               CLR_SEL_PERIPH_CLEAR: sel_clr = periph_clear[0];
               CLR_SEL_CLR1: sel_clr = periph_clear[1];
               default:      sel_clr = 1'b0;
            endcase
         end

         always_comb begin
            // a logic cell may bypass the bus for enables
            if (ce_sel == CE_SEL_CELL)
               sel_ce = ioe_cell_ce[g] ^ inv[INV_CE];
            else if (ce_sel == CE_SEL_ON)
               sel_ce = 1'b1;
            else
               sel_ce = clock_enable_slot[ce_sel] ^ inv[INV_CE];
         end

         always_comb begin
            if (oe_sel == OE_SEL_CELL)
               sel_oe = ioe_cell_oe[g] ^ inv[INV_OE];
            else if (oe_sel == OE_SEL_ON)
               sel_oe = 1'b1;
            else if (oe_sel < OE_SEL_CELL)
               sel_oe = output_enable_slot[oe_sel[2:0]] ^ inv[INV_OE];
            else
               sel_oe = 1'b0;
         end

         // selected clock is a level here; its rising edge is found
         // against clk, so it must be no faster than half of clk
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst)
               clk_prev_reg <= 1'b0;
            else
               clk_prev_reg <= sel_clk;
         end
         assign clk_rise = sel_clk & ~clk_prev_reg;

         // register serves input or output path
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst)
               q_reg <= IOE_REG_RST;
            else if (chip_rst)
               q_reg <= IOE_REG_RST;
            else if (sel_clr)
               q_reg <= IOE_REG_RST;
            else if (clk_rise && sel_ce)
               q_reg <= ioe_reg_is_input[g] ? pin_in[g] : row_d;
            else
               q_reg <= q_reg;
         end

         // data toward the row: registered pin or pin sampled each clk
         always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst)
               to_row_reg <= 1'b0;
            else if (dir == IOE_DIR_OUTPUT)
               to_row_reg <= 1'b0;
            else if (ioe_reg_used[g] && ioe_reg_is_input[g])
               to_row_reg <= q_reg;
            else
               to_row_reg <= pin_in[g];
         end
         assign ioe_to_row[g] = to_row_reg;

         // input, output or bidirectional buffer
         always_comb begin
            case (dir)
               IOE_DIR_OUTPUT: drive = 1'b1;
               IOE_DIR_BIDIR:  drive = sel_oe;
               default:        drive = 1'b0;
            endcase
         end

         // chip-wide enable released floats all pins
         assign pin_oe[g]  = drive & ~chip_oe_n;
         assign pin_out[g] = (ioe_reg_used[g] && !ioe_reg_is_input[g])
                             ? q_reg : row_d;
      end
   endgenerate
endmodule

// file: ioe_top_assertions.sv
// assertion checker bound to the i/o element top ports
module ioe_top_assertions
   import ioe_pkg::*;
(
   input wire logic                 clk,
   input wire logic                 sys_rst,
   input wire logic                 chip_rst,
   input wire logic                 chip_oe_n,
   input wire logic [NUM_IOE*2-1:0] ioe_dir,
   input wire logic [NUM_IOE-1:0]   ioe_reg_is_input,
   input wire logic [NUM_IOE-1:0]   ioe_reg_used,
   input wire logic [NUM_IOE*2-1:0] ioe_clr_sel,
   input wire logic [NUM_IOE*3-1:0] ioe_ce_sel,
   input wire logic [NUM_IOE*3-1:0] ioe_invert,
   input wire logic [NUM_IOE-1:0]   ioe_cell_ce,
   input wire logic [NUM_IOE-1:0]   pin_out,
   input wire logic [NUM_IOE-1:0]   pin_oe,
   input wire logic [NUM_IOE-1:0]   ioe_to_row,
   input wire ioe_cell_mode_type    cell_mode,
   input wire logic                 cell_data_input_three,
   input wire logic                 async_load_ctrl,
   input wire logic                 preset_ctrl_line,
   input wire logic                 cell_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic out_reg0;
   logic hold0;
   assign out_reg0 = ioe_reg_used[0] & ~ioe_reg_is_input[0];
   // element 0 output register with its cell enable low and no clear
   assign hold0 = out_reg0 & ioe_ce_sel[2:0] == CE_SEL_CELL & ~ioe_invert[1]
                  & ~ioe_cell_ce[0] & ioe_clr_sel[1:0] == CLR_SEL_NONE
                  & ~chip_rst;
   float_all_a: assert property (
      chip_oe_n |-> pin_oe == '0)
      else $error("pin driven while outputs disabled");
   cell_rst_a: assert property (
      chip_rst |-> !cell_q)
      else $error("cell output not cleared by chip reset");
   elem_rst_a: assert property (
      $past(chip_rst) && out_reg0 |-> !pin_out[0])
      else $error("element register survived chip reset");
   elem_hold_a: assert property (
      hold0 ##1 out_reg0 |-> $stable(pin_out[0]))
      else $error("element register changed with enable low");
   out_mode_row_a: assert property (
      $past(ioe_dir[1:0]) == IOE_DIR_OUTPUT |-> !ioe_to_row[0])
      else $error("row feed active in output mode");
   load_only_a: assert property (
      cell_mode == CELL_LOAD_ONLY && async_load_ctrl && !chip_rst
      |-> cell_q == cell_data_input_three)
      else $error("load line did not load third data input");
   preset_wins_a: assert property (
      cell_mode == CELL_LOAD_PRESET && preset_ctrl_line && !chip_rst
      |-> cell_q)
      else $error("preset line did not preset cell");
   load_preset_a: assert property (
      cell_mode == CELL_LOAD_PRESET && async_load_ctrl && !preset_ctrl_line
      && !chip_rst |-> cell_q == cell_data_input_three)
      else $error("load in preset mode gave wrong value");
   cover property (hold0);
   cover property (chip_oe_n ##1 !chip_oe_n);
   cover property (cell_mode == CELL_LOAD_ONLY && async_load_ctrl);
endmodule

bind ioe_top ioe_top_assertions u_assert (.*);

// file: ioe_board.sv
// board model that drives and senses the device pins
module ioe_board
   import ioe_pkg::*;
(
   input  wire logic [NUM_IOE-1:0] pin_out,
   input  wire logic [NUM_IOE-1:0] pin_oe,
   input  wire logic [NUM_IOE-1:0] drv_en,
   input  wire logic [NUM_IOE-1:0] drv_val,
   output logic      [NUM_IOE-1:0] pin_in
);
   // released pin shows the inverse so a stale level never passes
   always_comb begin
      for (int i = 0; i < NUM_IOE; i++) begin
         if (pin_oe[i])
            pin_in[i] = pin_out[i];
         else if (drv_en[i])
            pin_in[i] = drv_val[i];
         else
            pin_in[i] = ~drv_val[i];
      end
   end
endmodule

// file: testbench.sv
// self-checking bench for the i/o element block
module testbench
   import ioe_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk, sys_rst, chip_rst, chip_oe_n, ded_clk_invert;
   logic              cell_ce, cell_d, cell_data_input_three, cell_q;
   logic              async_load_ctrl, preset_ctrl_line;
   logic [5:0]        ded_in;
   logic [1:0]        ded_clk_pin;
   logic [11:0]       row_cell_in, col_route_in, line_invert;
   logic [35:0]       line_src_sel;
   logic [7:0]        ioe_dir, ioe_clk_sel, ioe_clr_sel;
   logic [11:0]       ioe_ce_sel, ioe_invert;
   logic [15:0]       ioe_oe_sel;
   logic [3:0]        ioe_reg_is_input, ioe_reg_used, ioe_row_data;
   logic [3:0]        ioe_cell_ce, ioe_cell_oe, drv_en, drv_val;
   logic [3:0]        pin_in, pin_out, pin_oe, ioe_to_row;
   logic [3:0]        global_distribution_line;
   ioe_cell_mode_type cell_mode;
   int                num_errors = 0;
   int                tests_run = 0;

   ioe_top DUT (.*);
   ioe_board u_board (.*);

   always #5 clk = ~clk;

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic settle(input int n);
      cyc(n);
      @(negedge clk);
   endtask
   // bus clock 0 comes from dedicated input 0; slow so no rise is lost
   task automatic bus_clk();
      cyc(1);
      ded_in[0] <= 1'b1;
      cyc(3);
      ded_in[0] <= 1'b0;
      settle(3);
   endtask

   task automatic t_cell();
      for (int v = 0; v < 2; v++) begin
         cyc(1);
         cell_data_input_three <= v[0];
         async_load_ctrl <= 1'b1;
         settle(1);
         chk(cell_q, v[0]);
         cyc(1);
         async_load_ctrl <= 1'b0;
         settle(2);
         chk(cell_q, v[0]);
      end
      cyc(1);
      cell_mode <= CELL_LOAD_PRESET;
      cell_data_input_three <= 1'b0;
      preset_ctrl_line <= 1'b1;
      async_load_ctrl <= 1'b1;
      settle(1);
      chk(cell_q, 1'b1);
      cyc(1);
      preset_ctrl_line <= 1'b0;
      settle(1);
      chk(cell_q, 1'b0);
      cyc(1);
      async_load_ctrl <= 1'b0;
      preset_ctrl_line <= 1'b1;
      chip_rst <= 1'b1;
      settle(1);
      chk(cell_q, 1'b0);
      cyc(1);
      chip_rst <= 1'b0;
      preset_ctrl_line <= 1'b0;
      cell_ce <= 1'b1;
      cell_d <= 1'b0;
      settle(3);
      chk(cell_q, 1'b0);
   endtask

   task automatic t_out_reg();
      cyc(1);
      ioe_row_data[0] <= 1'b1;
      bus_clk();
      chk(pin_out[0], 1'b1);
      cyc(1);
      ioe_row_data[0] <= 1'b0;
      ioe_ce_sel[2:0] <= CE_SEL_CELL;
      bus_clk();
      chk(pin_out[0], 1'b1);
      cyc(1);
      ioe_cell_ce[0] <= 1'b1;
      bus_clk();
      chk(pin_out[0], 1'b0);
      cyc(1);
      ioe_cell_ce[0] <= 1'b0;
      ioe_invert[1] <= 1'b1;
      ioe_row_data[0] <= 1'b1;
      bus_clk();
      chk(pin_out[0], 1'b1);
      cyc(1);
      chip_rst <= 1'b1;
      settle(1);
      chk(pin_out[0], 1'b0);
      cyc(1);
      chip_rst <= 1'b0;
      bus_clk();
      chk(pin_out[0], 1'b1);
      cyc(1);
      ioe_clr_sel[1:0] <= CLR_SEL_PERIPH_CLEAR;
      line_invert[8] <= 1'b1;
      settle(2);
      chk(pin_out[0], 1'b0);
   endtask

   task automatic t_ded_clk();
      cyc(1);
      ioe_clr_sel[1:0] <= CLR_SEL_NONE;
      ioe_row_data[0] <= 1'b0;
      ioe_clk_sel[1:0] <= CLK_SEL_PIN0;
      ded_clk_invert <= 1'b1;
      settle(3);
      cyc(1);
      ioe_row_data[0] <= 1'b1;
      ded_clk_pin[0] <= 1'b1;
      settle(3);
      chk(pin_out[0], 1'b0);
      cyc(1);
      ded_clk_pin[0] <= 1'b0;
      settle(3);
      chk(pin_out[0], 1'b1);
   endtask

   task automatic t_oe_glob();
      int map [8] = '{0, 1, 2, 3, 4, 5, 7, 9};
      // output mode always drives, so the enables need bidir
      cyc(1);
      ioe_dir[1:0] <= IOE_DIR_BIDIR;
      for (int k = 0; k < 8; k++) begin
         cyc(1);
         ioe_oe_sel[3:0] <= k[3:0];
         row_cell_in <= 12'h001 << map[k];
         settle(1);
         chk(pin_oe[0], 1'b1);
         cyc(1);
         row_cell_in <= ~(12'h001 << map[k]);
         settle(1);
         chk(pin_oe[0], 1'b0);
      end
      for (int i = 0; i < 12; i++) begin
         cyc(1);
         row_cell_in <= 12'h001 << i;
         col_route_in <= 12'h001 << i;
         ded_in[0] <= (i == 6);
         settle(1);
         chk(global_distribution_line,
             {i == 11, i == 9, i == 7, i == 6});
      end
      // one dedicated input in both senses on lines 7 and 9
      cyc(1);
      line_src_sel[23:21] <= 3'h1;
      line_src_sel[29:27] <= 3'h1;
      line_invert[9] <= 1'b1;
      ded_in[1] <= 1'b1;
      settle(1);
      chk(global_distribution_line, 4'hA);
      cyc(1);
      ded_in[1] <= 1'b0;
      settle(1);
      chk(global_distribution_line, 4'hC);
      cyc(1);
      ioe_oe_sel[3:0] <= OE_SEL_CELL;
      ioe_cell_oe[0] <= 1'b1;
      settle(1);
      chk(pin_oe[0], 1'b1);
      cyc(1);
      chip_oe_n <= 1'b1;
      settle(1);
      chk(pin_oe, 4'h0);
      cyc(1);
      chip_oe_n <= 1'b0;
   endtask

   task automatic t_input();
      for (int v = 0; v < 2; v++) begin
         cyc(1);
         drv_val[1] <= v[0];
         settle(2);
         chk(ioe_to_row[1], v[0]);
         chk(pin_oe[1], 1'b0);
      end
   endtask

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial begin
      {clk, chip_rst, chip_oe_n, ded_clk_invert, cell_ce, cell_d} = '0;
      {cell_data_input_three, async_load_ctrl, preset_ctrl_line} = '0;
      sys_rst = 1'b1;
      cell_mode = CELL_LOAD_ONLY;
      {ded_in, ded_clk_pin, row_cell_in, col_route_in, line_invert} = '0;
      line_src_sel = {SRC_COL_ROUTE, {4{SRC_ROW_CELL}}, 3'h0,
                      {6{SRC_ROW_CELL}}};
      ioe_dir = 8'h01;
      {ioe_clk_sel, ioe_clr_sel, ioe_invert, ioe_row_data} = '0;
      ioe_reg_used = 4'h1;
      ioe_reg_is_input = 4'h0;
      ioe_ce_sel = {4{CE_SEL_ON}};
      ioe_oe_sel = {4{OE_SEL_ON}};
      {ioe_cell_ce, ioe_cell_oe, drv_val} = '0;
      drv_en = 4'hE;
      cyc(6);
      sys_rst <= 1'b0;
      t_cell();
      t_out_reg();
      t_ded_clk();
      t_oe_glob();
      t_input();
      end_of_test();
   end

   initial begin
      #200us;
      num_errors++;
      end_of_test();
   end
endmodule
